// ### design/lcgk_detector.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
// How it works
// - loop detect in every state except open (code 0)
// - loop current full in opens, halved elsewhere
// - common mode flag set above threshold
// - flag with codes 1,3 zeroes Q1
// - flag with codes 5,7 zeroes Q2
// - loop filter coefficient is field [15:3]
// - coefficient 0 blocks, 4000h passes unfiltered
// - offhook and onhook thresholds give hysteresis
// - debounce flips after full opposite interval
// - mask interval after ringing burst ends
// - loop status set after debounce, read only
// - loop threshold above 61 mA disables
// - loop pending flag gated by enable
// - longitudinal current only in open states
// - longitudinal current is half of sum
// - ground key has its own filter
// - detect and release thresholds give hysteresis
// - ground key status after same debounce
// - loop status rise moves opens to active
// - ground key debounce is 1.25 ms count
// - ground key threshold above 16 mA disables
// - ground key pending flag gated by enable
// - code 1 forward active, 3 tip open
////////////////////////////////////////////////////////////////////////
module lcgk_detector #(
  parameter int TICK_CYCLES = lcgk_pkg::LCGK_TICK_CYCLES // cycles per tick
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] q1Current,
  input wire logic [15:0] q2Current,
  input wire logic [15:0] q5Current,
  input wire logic [15:0] q6Current,
  input wire logic [15:0] commonModeCurrent,
  input wire logic ringBurstNoOffset,
  output logic [2:0] lineDriveState,
  output logic loopClosureStatus,
  output logic groundKeyStatus,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [2:0] lfs_reg; // line drive state
  logic [15:0] offhk_reg; // loop detect threshold
  logic [15:0] onhk_reg; // loop release threshold
  logic [15:0] loopDbi_reg; // loop debounce ticks
  logic [15:0] loopCoef_reg; // loop filter word
  logic [15:0] loopMask_reg; // mask ticks
  logic [15:0] gkHi_reg; // ground key detect threshold
  logic [15:0] gkLo_reg; // ground key release threshold
  logic [15:0] gkDbi_reg; // ground key debounce ticks
  logic [15:0] gkCoef_reg; // ground key filter word
  logic [15:0] cmThr_reg; // common mode threshold
  logic loopIrqEn_reg;
  logic gkIrqEn_reg;
  logic loopPend_reg;
  logic gkPend_reg;
  logic cmh_reg; // common mode high flag
  logic [15:0] loopSense_reg; // sampled loop current
  logic [15:0] longSense_reg; // sampled longitudinal current
  logic [31:0] tickCnt_reg;
  logic tick; // one cycle per 1.25 ms
  logic ringPrev_reg;
  logic [15:0] maskCnt_reg;
  logic [31:0] prdata_reg;
  logic wrEn; // access phase write
  logic setup; // setup phase
  logic hit; // address decodes
  logic [31:0] rdNext;
  logic isOpen; // tip open or ring open
  logic signed [31:0] i1;
  logic signed [31:0] i2;
  logic signed [31:0] i5;
  logic signed [31:0] i6;
  logic signed [31:0] loopSum;
  logic signed [31:0] longSum;
  logic [15:0] loopNext;
  logic [15:0] longNext;
  logic loopRise; // loop status going to 1
  // per detector: 0 loop closure, 1 ground key
  logic signed [15:0] chSense [2];
  logic [15:0] chCoef [2];
  logic [15:0] chHi [2];
  logic [15:0] chLo [2];
  logic [15:0] chDbi [2];
  logic [15:0] chMax [2];
  logic chEnable [2];
  logic chMask [2];
  logic chStatus [2];
  logic chChange [2];

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh00007FFF) begin
      return 16'sh7FFF;
    end else if (v < -32'sh00008000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction : sat16

  // magnitude, so either polarity of line current trips
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    logic signed [31:0] w;
    w = 32'(v);
    if (w < 32'sh00000000) begin
      w = -w;
    end
    return w[15:0];
  endfunction : mag16

  ////////////////////////////////////////////////////////////////////////
  // sample tick
  always_ff @(posedge clk) begin
    if (rst) begin
      tickCnt_reg <= 32'h00000000;
    end else if (tickCnt_reg >= 32'(TICK_CYCLES - 1)) begin
      tickCnt_reg <= 32'h00000000;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h00000001;
    end
  end
  assign tick = (tickCnt_reg >= 32'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pwrite & hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit; // unmapped address
  assign prdata = prdata_reg;

  // read mux, also the decoder
  always_comb begin
    hit = 1'b1;
    rdNext = 32'h00000000;
    case (paddr)
      lcgk_pkg::LCGK_ADDR_LINEFEED: rdNext[2:0] = lfs_reg;
      lcgk_pkg::LCGK_ADDR_STATUS: begin // read only
        rdNext[lcgk_pkg::LCGK_STAT_LOOP_BIT] = chStatus[0];
        rdNext[lcgk_pkg::LCGK_STAT_GK_BIT] = chStatus[1];
        rdNext[lcgk_pkg::LCGK_STAT_CMH_BIT] = cmh_reg;
      end
      lcgk_pkg::LCGK_ADDR_IRQ_VEC: begin
        rdNext[lcgk_pkg::LCGK_IRQ_LOOP_BIT] = loopPend_reg;
        rdNext[lcgk_pkg::LCGK_IRQ_GK_BIT] = gkPend_reg;
      end
      lcgk_pkg::LCGK_ADDR_IRQ_EN: begin
        rdNext[lcgk_pkg::LCGK_IRQ_LOOP_BIT] = loopIrqEn_reg;
        rdNext[lcgk_pkg::LCGK_IRQ_GK_BIT] = gkIrqEn_reg;
      end
      lcgk_pkg::LCGK_ADDR_LOOP_SENSE: rdNext[15:0] = loopSense_reg;
      lcgk_pkg::LCGK_ADDR_LONG_SENSE: rdNext[15:0] = longSense_reg;
      lcgk_pkg::LCGK_ADDR_OFFHOOK: rdNext[15:0] = offhk_reg;
      lcgk_pkg::LCGK_ADDR_ONHOOK: rdNext[15:0] = onhk_reg;
      lcgk_pkg::LCGK_ADDR_LOOP_DBI: rdNext[15:0] = loopDbi_reg;
      lcgk_pkg::LCGK_ADDR_LOOP_LPF: rdNext[15:0] = loopCoef_reg;
      lcgk_pkg::LCGK_ADDR_LOOP_MASK: rdNext[15:0] = loopMask_reg;
      lcgk_pkg::LCGK_ADDR_GK_DETECT: rdNext[15:0] = gkHi_reg;
      lcgk_pkg::LCGK_ADDR_GK_RELEASE: rdNext[15:0] = gkLo_reg;
      lcgk_pkg::LCGK_ADDR_GK_DBI: rdNext[15:0] = gkDbi_reg;
      lcgk_pkg::LCGK_ADDR_GK_LPF: rdNext[15:0] = gkCoef_reg;
      lcgk_pkg::LCGK_ADDR_CM_THRESH: rdNext[15:0] = cmThr_reg;
      default: hit = 1'b0; // reads zero, error flagged
    endcase
  end

  // read data latched in setup, stable through access
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
    end else if (setup) begin
      prdata_reg <= rdNext;
    end
  end

  // plain configuration words
  always_ff @(posedge clk) begin
    if (rst) begin
      offhk_reg <= lcgk_pkg::LCGK_RST_OFFHOOK;
      onhk_reg <= lcgk_pkg::LCGK_RST_ONHOOK;
      loopDbi_reg <= lcgk_pkg::LCGK_RST_DBI;
      loopCoef_reg <= lcgk_pkg::LCGK_RST_LPF;
      loopMask_reg <= lcgk_pkg::LCGK_RST_MASK;
      gkHi_reg <= lcgk_pkg::LCGK_RST_GK_DETECT;
      gkLo_reg <= lcgk_pkg::LCGK_RST_GK_RELEASE;
      gkDbi_reg <= lcgk_pkg::LCGK_RST_DBI;
      gkCoef_reg <= lcgk_pkg::LCGK_RST_LPF;
      cmThr_reg <= lcgk_pkg::LCGK_RST_CM_THRESH;
      loopIrqEn_reg <= 1'b0;
      gkIrqEn_reg <= 1'b0;
    end else if (wrEn) begin
      case (paddr)
        lcgk_pkg::LCGK_ADDR_OFFHOOK: offhk_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_ONHOOK: onhk_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_LOOP_DBI: loopDbi_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_LOOP_LPF: loopCoef_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_LOOP_MASK: loopMask_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_GK_DETECT: gkHi_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_GK_RELEASE: gkLo_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_GK_DBI: gkDbi_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_GK_LPF: gkCoef_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_CM_THRESH: cmThr_reg <= pwdata[15:0];
        lcgk_pkg::LCGK_ADDR_IRQ_EN: begin
          loopIrqEn_reg <= pwdata[lcgk_pkg::LCGK_IRQ_LOOP_BIT];
          gkIrqEn_reg <= pwdata[lcgk_pkg::LCGK_IRQ_GK_BIT];
        end
        default: ; // read only or w1c words handled elsewhere
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line drive state, software written, hardware stepped
  assign loopRise = chChange[0] & ~chStatus[0];
  always_ff @(posedge clk) begin
    if (rst) begin
      lfs_reg <= lcgk_pkg::LCGK_RST_LFS;
    end else if (loopRise && lfs_reg == lcgk_pkg::LCGK_LFS_TIP_OPEN) begin
      lfs_reg <= lcgk_pkg::LCGK_LFS_FWD_ACTIVE;
    end else if (loopRise && lfs_reg == lcgk_pkg::LCGK_LFS_RING_OPEN) begin
      lfs_reg <= lcgk_pkg::LCGK_LFS_REV_ACTIVE;
    end else if (wrEn && paddr == lcgk_pkg::LCGK_ADDR_LINEFEED) begin
      lfs_reg <= pwdata[2:0]; // loses to a same-cycle hardware step
    end
  end
  assign lineDriveState = lfs_reg;

  ////////////////////////////////////////////////////////////////////////
  // common mode flag, live comparison every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cmh_reg <= 1'b0;
    end else begin
      cmh_reg <= (commonModeCurrent > cmThr_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input signal processing
  assign isOpen = (lfs_reg == lcgk_pkg::LCGK_LFS_TIP_OPEN) ||
                  (lfs_reg == lcgk_pkg::LCGK_LFS_RING_OPEN);
  always_comb begin
    i1 = $signed({16'h0000, q1Current});
    i2 = $signed({16'h0000, q2Current});
    i5 = $signed({16'h0000, q5Current});
    i6 = $signed({16'h0000, q6Current});
    // common mode clamps the grounded leg's transistor
    if (cmh_reg && (lfs_reg == lcgk_pkg::LCGK_LFS_FWD_ACTIVE ||
                    lfs_reg == lcgk_pkg::LCGK_LFS_TIP_OPEN)) begin
      i1 = 32'sh00000000;
    end
    if (cmh_reg && (lfs_reg == lcgk_pkg::LCGK_LFS_REV_ACTIVE ||
                    lfs_reg == lcgk_pkg::LCGK_LFS_RING_OPEN)) begin
      i2 = 32'sh00000000;
    end
    loopSum = i1 - i6 + i5 - i2;
    if (!isOpen) begin
      loopSum = loopSum >>> 1;
    end
    loopNext = sat16(loopSum);
    // longitudinal uses the raw currents
    longSum = ($signed({16'h0000, q1Current}) - $signed({16'h0000, q6Current})
             - $signed({16'h0000, q5Current}) + $signed({16'h0000, q2Current})) >>> 1;
    longNext = isOpen ? sat16(longSum) : 16'h0000;
  end

  // sense words refresh once per tick
  always_ff @(posedge clk) begin
    if (rst) begin
      loopSense_reg <= 16'h0000;
      longSense_reg <= 16'h0000;
    end else if (tick) begin
      loopSense_reg <= loopNext;
      longSense_reg <= longNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // post-ringing mask, started when a burst without offset stops
  always_ff @(posedge clk) begin
    if (rst) begin
      ringPrev_reg <= 1'b0;
      maskCnt_reg <= 16'h0000;
    end else begin
      ringPrev_reg <= ringBurstNoOffset;
      if (ringPrev_reg && !ringBurstNoOffset) begin
        maskCnt_reg <= loopMask_reg;
      end else if (tick && maskCnt_reg != 16'h0000) begin
        maskCnt_reg <= maskCnt_reg - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per detector wiring
  assign chSense[0] = loopSense_reg;
  assign chSense[1] = longSense_reg;
  assign chCoef[0] = loopCoef_reg;
  assign chCoef[1] = gkCoef_reg;
  assign chHi[0] = offhk_reg;
  assign chHi[1] = gkHi_reg;
  assign chLo[0] = onhk_reg;
  assign chLo[1] = gkLo_reg;
  assign chDbi[0] = loopDbi_reg;
  assign chDbi[1] = gkDbi_reg;
  assign chMax[0] = lcgk_pkg::LCGK_LOOP_TH_MAX;
  assign chMax[1] = lcgk_pkg::LCGK_GK_TH_MAX;
  assign chEnable[0] = (lfs_reg != lcgk_pkg::LCGK_LFS_OPEN);
  assign chEnable[1] = isOpen;
  assign chMask[0] = (maskCnt_reg != 16'h0000);
  assign chMask[1] = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // filter, comparator, debounce per detector
  for (genvar g = 0; g < 2; g++) begin : gDet
    logic signed [15:0] filt_reg;
    logic signed [15:0] filtNext;
    logic cmp_reg;
    logic [15:0] dbCnt_reg;
    logic status_reg;
    logic [12:0] kField;
    logic [15:0] mag;
    logic thOk;
    logic signed [31:0] diff;
    logic signed [31:0] acc;

    // first order low pass: y += (x - y) * k / 800h
    always_comb begin
      kField = chCoef[g][15:lcgk_pkg::LCGK_COEF_LSB];
      if (kField > lcgk_pkg::LCGK_COEF_UNITY) begin
        kField = lcgk_pkg::LCGK_COEF_UNITY; // above unity would ring
      end
      diff = 32'(chSense[g]) - 32'(filt_reg);
      acc = 32'(filt_reg) +
            ((diff * $signed({19'h00000, kField})) >>> lcgk_pkg::LCGK_COEF_SHIFT);
      filtNext = sat16(acc);
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        filt_reg <= 16'sh0000;
      end else if (tick) begin
        filt_reg <= filtNext;
      end
    end

    // hysteresis comparator on magnitude
    assign mag = mag16(filt_reg);
    assign thOk = (chHi[g] <= chMax[g]) && (chLo[g] <= chMax[g]);
    always_ff @(posedge clk) begin
      if (rst) begin
        cmp_reg <= 1'b0;
      end else if (tick) begin
        if (!chEnable[g] || !thOk) begin
          cmp_reg <= 1'b0;
        end else if (chMask[g]) begin
          cmp_reg <= status_reg; // transients ignored
        end else if (!cmp_reg && mag > chHi[g]) begin
          cmp_reg <= 1'b1;
        end else if (cmp_reg && mag < chLo[g]) begin
          cmp_reg <= 1'b0;
        end
      end
    end

    // debounce: flips once opposite for the full count
    assign chChange[g] = tick && (cmp_reg != status_reg) && (dbCnt_reg >= chDbi[g]);
    always_ff @(posedge clk) begin
      if (rst) begin
        dbCnt_reg <= 16'h0000;
        status_reg <= 1'b0;
      end else if (tick) begin
        if (cmp_reg == status_reg) begin
          dbCnt_reg <= 16'h0000; // any agreement restarts the wait
        end else if (dbCnt_reg >= chDbi[g]) begin
          dbCnt_reg <= 16'h0000;
          status_reg <= cmp_reg;
        end else begin
          dbCnt_reg <= dbCnt_reg + 16'h0001;
        end
      end
    end
    assign chStatus[g] = status_reg;
  end

  assign loopClosureStatus = chStatus[0];
  assign groundKeyStatus = chStatus[1];

  ////////////////////////////////////////////////////////////////////////
  // pending flags, write one to clear, a new change wins
  always_ff @(posedge clk) begin
    if (rst) begin
      loopPend_reg <= 1'b0;
      gkPend_reg <= 1'b0;
    end else begin
      if (chChange[0]) begin
        loopPend_reg <= 1'b1;
      end else if (wrEn && paddr == lcgk_pkg::LCGK_ADDR_IRQ_VEC &&
                   pwdata[lcgk_pkg::LCGK_IRQ_LOOP_BIT]) begin
        loopPend_reg <= 1'b0;
      end
      if (chChange[1]) begin
        gkPend_reg <= 1'b1;
      end else if (wrEn && paddr == lcgk_pkg::LCGK_ADDR_IRQ_VEC &&
                   pwdata[lcgk_pkg::LCGK_IRQ_GK_BIT]) begin
        gkPend_reg <= 1'b0;
      end
    end
  end

  // interrupt line, level until cleared
  assign irq = (loopPend_reg & loopIrqEn_reg) | (gkPend_reg & gkIrqEn_reg);

endmodule : lcgk_detector

// ### design/lcgk_pkg.sv
package lcgk_pkg;

  ////////////////////////////////////////////////////////////////////////
  // apb byte addresses, one aligned word each
  localparam logic [7:0] LCGK_ADDR_LINEFEED = 8'h00; // line drive state
  localparam logic [7:0] LCGK_ADDR_STATUS = 8'h04; // hook trip status
  localparam logic [7:0] LCGK_ADDR_IRQ_VEC = 8'h08; // pending, w1c
  localparam logic [7:0] LCGK_ADDR_IRQ_EN = 8'h0C; // enables
  localparam logic [7:0] LCGK_ADDR_LOOP_SENSE = 8'h10; // ro
  localparam logic [7:0] LCGK_ADDR_LONG_SENSE = 8'h14; // ro
  localparam logic [7:0] LCGK_ADDR_OFFHOOK = 8'h18;
  localparam logic [7:0] LCGK_ADDR_ONHOOK = 8'h1C;
  localparam logic [7:0] LCGK_ADDR_LOOP_DBI = 8'h20;
  localparam logic [7:0] LCGK_ADDR_LOOP_LPF = 8'h24;
  localparam logic [7:0] LCGK_ADDR_LOOP_MASK = 8'h28;
  localparam logic [7:0] LCGK_ADDR_GK_DETECT = 8'h2C;
  localparam logic [7:0] LCGK_ADDR_GK_RELEASE = 8'h30;
  localparam logic [7:0] LCGK_ADDR_GK_DBI = 8'h34;
  localparam logic [7:0] LCGK_ADDR_GK_LPF = 8'h38;
  localparam logic [7:0] LCGK_ADDR_CM_THRESH = 8'h3C;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int LCGK_STAT_LOOP_BIT = 0; // loop closure status
  localparam int LCGK_STAT_GK_BIT = 1; // ground key status
  localparam int LCGK_STAT_CMH_BIT = 2; // common mode high flag
  localparam int LCGK_IRQ_LOOP_BIT = 0; // loop irq pending / enable
  localparam int LCGK_IRQ_GK_BIT = 1; // ground key irq pending / enable
  localparam int LCGK_COEF_LSB = 3; // coefficient field is [15:3]
  localparam int LCGK_COEF_SHIFT = 11; // field 800h is unity gain
  localparam logic [12:0] LCGK_COEF_UNITY = 13'h0800;

  ////////////////////////////////////////////////////////////////////////
  // line drive state codes
  localparam logic [2:0] LCGK_LFS_OPEN = 3'h0;
  localparam logic [2:0] LCGK_LFS_FWD_ACTIVE = 3'h1;
  localparam logic [2:0] LCGK_LFS_TIP_OPEN = 3'h3;
  localparam logic [2:0] LCGK_LFS_REV_ACTIVE = 3'h5;
  localparam logic [2:0] LCGK_LFS_RING_OPEN = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // timing: one sample and debounce tick every 1.25 ms
  localparam int LCGK_CLK_PERIOD_NS = 20;
  localparam real LCGK_TICK_MS = 1.25;
  localparam int LCGK_TICK_CYCLES = int'(LCGK_TICK_MS * 1.0e6 / LCGK_CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////
  // usable threshold limits, in threshold lsb of 3.097 uA (3097 nA)
  localparam int LCGK_LSB_NA = 3097;
  localparam int LCGK_LOOP_LIMIT_NA = 61000000; // 61 mA
  localparam int LCGK_GK_LIMIT_NA = 16000000; // 16 mA
  localparam logic [15:0] LCGK_LOOP_TH_MAX = 16'(LCGK_LOOP_LIMIT_NA / LCGK_LSB_NA);
  localparam logic [15:0] LCGK_GK_TH_MAX = 16'(LCGK_GK_LIMIT_NA / LCGK_LSB_NA);

  ////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [2:0] LCGK_RST_LFS = 3'h0;
  localparam logic [15:0] LCGK_RST_LPF = 16'h0A10; // about 20 Hz
  localparam logic [15:0] LCGK_RST_OFFHOOK = 16'h11A8; // about 14 mA
  localparam logic [15:0] LCGK_RST_ONHOOK = 16'h0C9D; // about 10 mA
  localparam logic [15:0] LCGK_RST_GK_DETECT = 16'h08D4; // about 7 mA
  localparam logic [15:0] LCGK_RST_GK_RELEASE = 16'h064E; // about 5 mA
  localparam logic [15:0] LCGK_RST_DBI = 16'h0008; // 10 ms
  localparam logic [15:0] LCGK_RST_MASK = 16'h0000;
  localparam logic [15:0] LCGK_RST_CM_THRESH = 16'h1000;

endpackage : lcgk_pkg

// ### verif/lcgk_monitor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// port watcher for the detector
module lcgk_monitor #(
  parameter int TICK_CYCLES = 4 // cycles per tick
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] lineDriveState,
  input wire logic loopClosureStatus,
  input wire logic groundKeyStatus,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int tickCnt; // mirrors the design tick counter
  wire logic wrAcc = psel && penable && pwrite; // write access phase
  wire logic lfsWr = wrAcc && paddr == 8'h00; // software linefeed write
  // tick count restarted by reset, as in the design
  always_ff @(posedge clk) begin
    if (rst || tickCnt == TICK_CYCLES - 1) begin
      tickCnt <= 0;
    end else begin
      tickCnt <= tickCnt + 1;
    end
  end
  // status rise while still in an open state
  sequence s_trip_tip;
    lineDriveState == 3'h3 ##1 $rose(loopClosureStatus);
  endsequence
  sequence s_trip_ring;
    lineDriveState == 3'h7 ##1 $rose(loopClosureStatus);
  endsequence
  property p_step_fwd;
    s_trip_tip |-> lineDriveState == 3'h1;
  endproperty
  a_step_fwd: assert property (p_step_fwd) else $error("no tip open step");
  property p_step_rev;
    s_trip_ring |-> lineDriveState == 3'h5;
  endproperty
  a_step_rev: assert property (p_step_rev) else $error("no ring open step");
  property p_lfs_src;
    $changed(lineDriveState) |-> $past(lfsWr) || $rose(loopClosureStatus);
  endproperty
  a_lfs_src: assert property (p_lfs_src) else $error("linefeed moved alone");
  property p_gk_no_step;
    $rose(groundKeyStatus) && !$rose(loopClosureStatus) && !$past(lfsWr) |-> $stable(lineDriveState);
  endproperty
  a_gk_no_step: assert property (p_gk_no_step) else $error("ground key stepped");
  property p_loop_tick;
    $changed(loopClosureStatus) |-> tickCnt == 0;
  endproperty
  a_loop_tick: assert property (p_loop_tick) else $error("loop status off tick");
  property p_gk_tick;
    $changed(groundKeyStatus) |-> tickCnt == 0;
  endproperty
  a_gk_tick: assert property (p_gk_tick) else $error("gk status off tick");
  property p_irq_rise;
    $rose(irq) |-> $changed(loopClosureStatus) || $changed(groundKeyStatus) || $past(wrAcc);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
  property p_irq_fall;
    $fell(irq) |-> $past(wrAcc);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_err;
    pslverr |-> psel && penable && prdata == 32'h0000_0000 && pready;
  endproperty
  a_err: assert property (p_err) else $error("bad error response");
endmodule : lcgk_monitor

bind lcgk_detector lcgk_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .lineDriveState(lineDriveState),
  .loopClosureStatus(loopClosureStatus), .groundKeyStatus(groundKeyStatus), .irq(irq)
);

// ### verif/lcgk_line_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// sensed linefeed currents; mode 0 open, 1 loop, 2 ring grounded, 3 loop with cm
module lcgk_line_model (
  input wire logic [1:0] lineMode,
  input wire logic [15:0] level,
  output logic [15:0] q1Current,
  output logic [15:0] q2Current,
  output logic [15:0] q5Current,
  output logic [15:0] q6Current,
  output logic [15:0] commonModeCurrent
);
  // loop current flows through q1 and q5, ring to ground through q5 only
  assign q1Current = lineMode[0] ? level : 16'h0000;
  assign q5Current = (lineMode != 2'h0) ? level : 16'h0000;
  // return paths idle: only forward polarity is modelled
  assign q2Current = 16'h0000;
  assign q6Current = 16'h0000;
  assign commonModeCurrent = (lineMode == 2'h3) ? level : 16'h0000;
endmodule : lcgk_line_model

// ### verif/lcgk_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
////////////////////////////////////////////////////////////////////////
module testbench;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} lcgk_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, lcs, gks, irq;
  logic [15:0] q1, q2, q5, q6, cm;
  logic [2:0] lfs;
  logic [1:0] lineMode = 2'h0; // far side loop condition
  logic ring = 1'b0; // ringing burst without offset, far side
  int error_cnt = 0;
  int num_checks = 0;
  // reads expect d, writes send d
  lcgk_row_t rows [16] = '{'{0, 8'h18, 32'h11A8}, '{0, 8'h1C, 32'h0C9D}, '{0, 8'h20, 32'h8},
    '{0, 8'h24, 32'h0A10}, '{0, 8'h28, 32'h0}, '{0, 8'h2C, 32'h08D4}, '{0, 8'h30, 32'h064E},
    '{0, 8'h34, 32'h8}, '{0, 8'h38, 32'h0A10}, '{0, 8'h3C, 32'h1000}, '{0, 8'h00, 32'h0},
    '{0, 8'h0C, 32'h0}, '{1, 8'h04, 32'h7}, '{0, 8'h04, 32'h0}, '{1, 8'h20, 32'h0},
    '{0, 8'h20, 32'h0}};
  initial forever #10 clk = ~clk;
  lcgk_detector #(.TICK_CYCLES(4)) dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .q1Current(q1), .q2Current(q2), .q5Current(q5), .q6Current(q6),
    .commonModeCurrent(cm), .ringBurstNoOffset(ring), .lineDriveState(lfs),
    .loopClosureStatus(lcs), .groundKeyStatus(gks), .irq(irq));
  lcgk_line_model line (.lineMode(lineMode), .level(16'h2000), .q1Current(q1),
    .q2Current(q2), .q5Current(q5), .q6Current(q6), .commonModeCurrent(cm));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // one apb transfer; held until pready seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      print_verdict();
    end
  endtask : apb
  // bounded wait for a status level
  task automatic wait_stat(input logic gk, input logic v);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if ((gk ? gks : lcs) === v) break;
    end
    @(negedge clk);
    `CHK(n < 400, 1'b1)
    if (n >= 400) print_verdict();
  endtask : wait_stat
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK(rd, rows[i].d)
    end
    apb(0, 8'h40, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    $display("registers done");
    apb(1, 8'h0C, 32'h3);
    apb(1, 8'h24, 32'h0);
    apb(1, 8'h38, 32'h4000);
    apb(1, 8'h00, 32'h1);
    lineMode <= 2'h1;
    repeat (40) @(posedge clk);
    @(negedge clk);
    `CHK(lcs, 1'b0)
    apb(1, 8'h24, 32'h4000);
    wait_stat(0, 1);
    `CHK(irq, 1'b1)
    apb(0, 8'h10, 0);
    `CHK(rd, 32'h2000)
    lineMode <= 2'h3;
    apb(1, 8'h3C, 32'h0100);
    repeat (16) @(posedge clk);
    apb(0, 8'h04, 0);
    `CHK(rd[2:0], 3'h5)
    apb(0, 8'h10, 0);
    `CHK(rd, 32'h1000)
    apb(1, 8'h08, 32'h3);
    @(negedge clk);
    `CHK(irq, 1'b0)
    $display("loop closure done");
    @(posedge clk);
    lineMode <= 2'h0;
    wait_stat(0, 0);
    `CHK(irq, 1'b1)
    apb(1, 8'h08, 32'h3);
    apb(1, 8'h18, 32'hFFFF);
    apb(1, 8'h00, 32'h3);
    lineMode <= 2'h2;
    wait_stat(1, 1);
    `CHK({lcs, lfs}, 4'h3)
    apb(0, 8'h10, 0);
    `CHK(rd, 32'h2000)
    apb(0, 8'h14, 0);
    `CHK(rd, 32'hF000)
    apb(1, 8'h18, 32'h11A8);
    wait_stat(0, 1);
    `CHK(lfs, 3'h1)
    wait_stat(1, 0);
    apb(0, 8'h14, 0);
    `CHK(rd, 32'h0)
    $display("ground key done");
    // burst end masks the loop opening for 64 ticks
    apb(1, 8'h28, 32'h40);
    ring <= 1'b1;
    @(posedge clk);
    ring <= 1'b0;
    lineMode <= 2'h0;
    repeat (40) @(posedge clk);
    @(negedge clk);
    `CHK(lcs, 1'b1)
    wait_stat(0, 0);
    $display("mask done");
    // mid-run reset brings state and words back
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK({lfs, lcs, gks, irq}, 6'h00)
    apb(0, 8'h20, 0);
    `CHK(rd, 32'h8)
    $display("reset done");
    print_verdict();
  end
endmodule : testbench
